/* design/cei_defines.vh */
// register offsets, field positions and reset values for the counter irq block
`ifndef CEI_DEFINES_VH
`define CEI_DEFINES_VH
`define CEI_NUM_INST 6
`define CEI_OFF_MASK 12'h000
`define CEI_OFF_CFG 12'h004
`define CEI_OFF_STAT 12'h008
`define CEI_OFF_LOST 12'h00c
`define CEI_OFF_IRQ_STAT 12'h010
`define CEI_OFF_IRQ_CLR 12'h014
`define CEI_OFF_IRQ_EN 12'h018
`define CEI_OFF_SEL 12'h01c
`define CEI_MASK_HP 0
`define CEI_MASK_LP 1
`define CEI_MASK_OV 2
`define CEI_MASK_UN 3
`define CEI_MASK_RESET 4'h0
`define CEI_MODE_LOW_MIN 4'h2
`define CEI_MODE_MAX 4'h9
`define CEI_IRQ_LOST 0
`define CEI_IRQ_START 1
`define CEI_STAT_EN_LSB 0
`define CEI_STAT_EX_LSB 8
`define CEI_STAT_PE_LSB 16
`endif

/* design/cei_ctrl.v */
// counter event interrupt controller with apb registers
`timescale 1ns/10ps
// Function
// - on a fire, start the handler routine chosen at configuration
// - arm the interrupt on each entry into run mode if autostart set
// - autostart comes from the loaded program image, not software writes
// - overflow mask zero blocks the handler on overflow
// - underflow mask zero blocks the handler; mask used in modes 2 to 9
// - high preset mask zero blocks the handler on high preset
// - low preset mask zero blocks the handler; mask used in modes 2 to 9
// - event masks retained over power loss, set by software or restored from retained storage
// - read-only status bit shows whether the interrupt is enabled
// - executing flag set when handler servicing begins, any of four events
// - overflow counts upward through limit, underflow downward through limit
// - executing flag cleared when handler servicing completes
// - pending flag set when trigger cannot be serviced, cleared when taken
// - one active and one pending; a further trigger sets the lost flag
// - lost flag set only by hardware and sticky; software reads or clears it
// - up to six independent instances with own mask and status bits
`include "cei_defines.vh"
module cei_ctrl #(
  parameter NUM_INST = `CEI_NUM_INST
)(
  input wire clock_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [NUM_INST-1:0] hp_reached_i,
  input wire [NUM_INST-1:0] lp_reached_i,
  input wire [NUM_INST-1:0] overflow_i,
  input wire [NUM_INST-1:0] underflow_i,
  input wire [4*NUM_INST-1:0] counter_mode_i,
  input wire [NUM_INST-1:0] autostart_bit_i,
  input wire [4*NUM_INST-1:0] mask_restore_i,
  input wire mask_restore_valid_i,
  input wire run_mode_i,
  input wire [NUM_INST-1:0] handler_done_i,
  output reg [NUM_INST-1:0] handler_start_o,
  output reg [3*NUM_INST-1:0] handler_id_o,
  output reg [4*NUM_INST-1:0] mask_retain_o,
  output reg irq_o
);

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  localparam EW = 6 * NUM_INST + 1;
  wire [EW-1:0] ev_raw = {handler_done_i, autostart_bit_i, underflow_i,
                          overflow_i, lp_reached_i, hp_reached_i, run_mode_i};
  reg [EW-1:0] ev_meta_reg;
  reg [EW-1:0] ev_sync_reg;
  reg [EW-1:0] ev_prev_reg;
  always @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      ev_meta_reg <= {EW{1'b0}};
      ev_sync_reg <= {EW{1'b0}};
      ev_prev_reg <= {EW{1'b0}};
    end
    else
    begin
      ev_meta_reg <= ev_raw;
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end
  // events are edges of synchronised levels
  wire [EW-1:0] ev_rise = ev_sync_reg & ~ev_prev_reg;
  wire run_rise = ev_rise[0];
  wire [NUM_INST-1:0] hp_ev = ev_rise[NUM_INST:1];
  wire [NUM_INST-1:0] lp_ev = ev_rise[2*NUM_INST:NUM_INST+1];
  wire [NUM_INST-1:0] ov_ev = ev_rise[3*NUM_INST:2*NUM_INST+1];
  wire [NUM_INST-1:0] un_ev = ev_rise[4*NUM_INST:3*NUM_INST+1];
  wire [NUM_INST-1:0] as_lvl = ev_sync_reg[5*NUM_INST:4*NUM_INST+1];
  wire [NUM_INST-1:0] done_ev = ev_rise[6*NUM_INST:5*NUM_INST+1];

  reg [4*NUM_INST-1:0] mode_meta_reg;
  reg [4*NUM_INST-1:0] mode_sync_reg;
  reg [4*NUM_INST-1:0] rest_meta_reg;
  reg [4*NUM_INST-1:0] rest_sync_reg;
  reg rv_meta_reg;
  reg rv_sync_reg;
  reg rv_prev_reg;
  always @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_meta_reg <= {4*NUM_INST{1'b0}};
      mode_sync_reg <= {4*NUM_INST{1'b0}};
      rest_meta_reg <= {4*NUM_INST{1'b0}};
      rest_sync_reg <= {4*NUM_INST{1'b0}};
      rv_meta_reg <= 1'b0;
      rv_sync_reg <= 1'b0;
      rv_prev_reg <= 1'b0;
    end
    // data and strobe share one sync depth: data must settle first
    else
    begin
      mode_meta_reg <= counter_mode_i;
      mode_sync_reg <= mode_meta_reg;
      rest_meta_reg <= mask_restore_i;
      rest_sync_reg <= rest_meta_reg;
      rv_meta_reg <= mask_restore_valid_i;
      rv_sync_reg <= rv_meta_reg;
      rv_prev_reg <= rv_sync_reg;
    end
  end
  wire restore_ev = rv_sync_reg & ~rv_prev_reg;

  // ------------------------------------------------------------
  // apb register access
  // ------------------------------------------------------------
  localparam RS_MASK = 0;
  localparam RS_CFG = 1;
  localparam RS_STAT = 2;
  localparam RS_LOST = 3;
  localparam RS_IRQ_STAT = 4;
  localparam RS_IRQ_CLR = 5;
  localparam RS_IRQ_EN = 6;
  localparam RS_SEL = 7;

  // one-hot register select, shared by write strobes and read mux
  function [7:0] addr_sel;
    input [11:0] a;
    begin
      addr_sel = 8'h00;
      if (a == `CEI_OFF_MASK)
        addr_sel[RS_MASK] = 1'b1;
      else if (a == `CEI_OFF_CFG)
        addr_sel[RS_CFG] = 1'b1;
      else if (a == `CEI_OFF_STAT)
        addr_sel[RS_STAT] = 1'b1;
      else if (a == `CEI_OFF_LOST)
        addr_sel[RS_LOST] = 1'b1;
      else if (a == `CEI_OFF_IRQ_STAT)
        addr_sel[RS_IRQ_STAT] = 1'b1;
      else if (a == `CEI_OFF_IRQ_CLR)
        addr_sel[RS_IRQ_CLR] = 1'b1;
      else if (a == `CEI_OFF_IRQ_EN)
        addr_sel[RS_IRQ_EN] = 1'b1;
      else if (a == `CEI_OFF_SEL)
        addr_sel[RS_SEL] = 1'b1;
    end
  endfunction

  // an unmapped address selects nothing and answers with an error
  wire [7:0] rsel = addr_sel(paddr_i);
  wire acc = psel_i & penable_i & pready_o;
  wire wr = acc & pwrite_i;
  wire wr_mask = wr & rsel[RS_MASK];
  wire wr_lost = wr & rsel[RS_LOST];
  wire wr_iclr = wr & rsel[RS_IRQ_CLR];
  wire wr_ien = wr & rsel[RS_IRQ_EN];
  wire wr_sel = wr & rsel[RS_SEL];

  reg [4*NUM_INST-1:0] mask_reg;
  reg [NUM_INST-1:0] enabled_reg;
  wire [NUM_INST-1:0] exec_flag;
  wire [NUM_INST-1:0] pend_flag;
  // service slot: idle, handler running, running with one queued
  localparam SLOT_IDLE = 3'b001;
  localparam SLOT_BUSY = 3'b010;
  localparam SLOT_QUEUED = 3'b100;
  reg [NUM_INST-1:0] lost_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_en_reg;
  reg [3*NUM_INST-1:0] sel_reg;
  reg [NUM_INST-1:0] start_pulse;
  reg [NUM_INST-1:0] lost_set;

  // mode window in which the low side masks take effect
  function low_mode_ok;
    input [3:0] m;
    begin
      low_mode_ok = (m >= `CEI_MODE_LOW_MIN) && (m <= `CEI_MODE_MAX);
    end
  endfunction

  // ------------------------------------------------------------
  // per instance servicing slots
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_INST; g = g + 1)
    begin : g_inst
      wire [3:0] mk = mask_reg[4*g+3:4*g];
      wire low_ok = low_mode_ok(mode_sync_reg[4*g+3:4*g]);
      // events arrive already classified by direction of travel
      wire trig = enabled_reg[g] & (
        (hp_ev[g] & mk[`CEI_MASK_HP]) |
        (ov_ev[g] & mk[`CEI_MASK_OV]) |
        (low_ok & lp_ev[g] & mk[`CEI_MASK_LP]) |
        (low_ok & un_ev[g] & mk[`CEI_MASK_UN]));
      wire done = done_ev[g];
      reg [2:0] slot_reg;
      assign exec_flag[g] = slot_reg[2] | slot_reg[1];
      assign pend_flag[g] = slot_reg[2];
      always @(posedge clock_i or negedge rstn)
      begin
        if (!rstn)
        begin
          enabled_reg[g] <= 1'b0;
          slot_reg <= SLOT_IDLE;
          lost_reg[g] <= 1'b0;
          start_pulse[g] <= 1'b0;
          lost_set[g] <= 1'b0;
        end
        else
        begin
          // autostart level is image-loaded, never software written
          if (run_rise & as_lvl[g])
            enabled_reg[g] <= 1'b1;
          else if (!ev_sync_reg[0])
            enabled_reg[g] <= 1'b0;
          start_pulse[g] <= 1'b0;
          lost_set[g] <= 1'b0;
          case (slot_reg)
            SLOT_IDLE:
            begin
              if (trig)
              begin
                slot_reg <= SLOT_BUSY;
                start_pulse[g] <= 1'b1;
              end
            end
            SLOT_BUSY:
            begin
              // a trigger landing on completion restarts at once
              if (done & trig)
                start_pulse[g] <= 1'b1;
              else if (done)
                slot_reg <= SLOT_IDLE;
              else if (trig)
                slot_reg <= SLOT_QUEUED;
            end
            SLOT_QUEUED:
            begin
              if (done)
              begin
                start_pulse[g] <= 1'b1;
                if (!trig)
                  slot_reg <= SLOT_BUSY;
              end
              else if (trig)
                lost_set[g] <= 1'b1;
            end
            default:
              slot_reg <= SLOT_IDLE;
          endcase
          // hardware set beats a software clear in the same cycle
          if (trig & ~done & slot_reg[2])
            lost_reg[g] <= 1'b1;
          else if (wr_lost & pwdata_i[g])
            lost_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // masks, selection, interrupt status
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_reg <= {NUM_INST{`CEI_MASK_RESET}};
      sel_reg <= {3*NUM_INST{1'b0}};
      irq_stat_reg <= 2'h0;
      irq_en_reg <= 2'h0;
    end
    else
    begin
      // masks restored from retained storage after power-up
      if (restore_ev)
        mask_reg <= rest_sync_reg;
      else if (wr_mask)
        mask_reg <= pwdata_i[4*NUM_INST-1:0];
      if (wr_sel)
        sel_reg <= pwdata_i[3*NUM_INST-1:0];
      if (wr_ien)
        irq_en_reg <= pwdata_i[1:0];
      irq_stat_reg[`CEI_IRQ_LOST] <= (|lost_set) |
        (irq_stat_reg[`CEI_IRQ_LOST] & ~(wr_iclr & pwdata_i[`CEI_IRQ_LOST]));
      irq_stat_reg[`CEI_IRQ_START] <= (|start_pulse) |
        (irq_stat_reg[`CEI_IRQ_START] &
         ~(wr_iclr & pwdata_i[`CEI_IRQ_START]));
    end
  end

  // ------------------------------------------------------------
  // registered outputs and read mux
  // ------------------------------------------------------------
  reg [31:0] rd_next;
  reg err_next;
  always @*
  begin
    rd_next = 32'h0;
    err_next = 1'b0;
    if (rsel[RS_MASK])
      rd_next[4*NUM_INST-1:0] = mask_reg;
    else if (rsel[RS_CFG])
      rd_next[NUM_INST-1:0] = as_lvl;
    else if (rsel[RS_STAT])
    begin
      rd_next[`CEI_STAT_EN_LSB +: NUM_INST] = enabled_reg;
      rd_next[`CEI_STAT_EX_LSB +: NUM_INST] = exec_flag;
      rd_next[`CEI_STAT_PE_LSB +: NUM_INST] = pend_flag;
    end
    else if (rsel[RS_LOST])
      rd_next[NUM_INST-1:0] = lost_reg;
    else if (rsel[RS_IRQ_STAT])
      rd_next[1:0] = irq_stat_reg;
    else if (rsel[RS_IRQ_CLR])
      rd_next = 32'h0;
    else if (rsel[RS_IRQ_EN])
      rd_next[1:0] = irq_en_reg;
    else if (rsel[RS_SEL])
      rd_next[3*NUM_INST-1:0] = sel_reg;
    else
      err_next = 1'b1;
  end

  always @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      handler_start_o <= {NUM_INST{1'b0}};
      handler_id_o <= {3*NUM_INST{1'b0}};
      mask_retain_o <= {NUM_INST{`CEI_MASK_RESET}};
      irq_o <= 1'b0;
    end
    else
    begin
      // one wait state: ready is high in the second access cycle
      pready_o <= psel_i & penable_i & ~pready_o;
      if (psel_i & penable_i & ~pready_o)
      begin
        prdata_o <= pwrite_i ? 32'h0 : rd_next;
        pslverr_o <= err_next;
      end
      else
        pslverr_o <= 1'b0;
      handler_start_o <= start_pulse;
      handler_id_o <= sel_reg;
      mask_retain_o <= mask_reg;
      irq_o <= |(irq_stat_reg & irq_en_reg);
    end
  end
endmodule // cei_ctrl

/* verif/cei_exec_model.sv */
// handler executor model answering start pulses with done levels
`timescale 1ns/10ps
module cei_exec_model #(
  parameter N = 6
)(
  input wire clock_i,
  input wire [N-1:0] start_i,
  input wire stall_i,
  input wire [7:0] delay_i,
  output reg [N-1:0] done_o
);
  integer i;
  reg [8:0] cnt [0:N-1];
  reg [N-1:0] busy = 0;
  initial done_o = 0;
  // done held 6 cycles so the design's synchroniser sees its edge
  always @(posedge clock_i)
    for (i = 0; i < N; i = i + 1)
    begin
      if (start_i[i])
        cnt[i] <= 9'h000;
      else if (busy[i] && !stall_i)
        cnt[i] <= cnt[i] + 9'h001;
      if (start_i[i])
        busy[i] <= 1'b1;
      else if (cnt[i] == delay_i + 6)
        busy[i] <= 1'b0;
      done_o[i] <= busy[i] && cnt[i] >= delay_i && cnt[i] < delay_i + 6;
    end
endmodule // cei_exec_model

/* verif/cei_monitor.sv */
// port checker for the counter irq controller
`timescale 1ns/10ps
module cei_monitor #(
  parameter NUM_INST = 6
)(
  input wire clock_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire [NUM_INST-1:0] hp_reached_i,
  input wire [NUM_INST-1:0] lp_reached_i,
  input wire [NUM_INST-1:0] overflow_i,
  input wire [NUM_INST-1:0] underflow_i,
  input wire mask_restore_valid_i,
  input wire [NUM_INST-1:0] handler_done_i,
  input wire [NUM_INST-1:0] handler_start_o,
  input wire [3*NUM_INST-1:0] handler_id_o,
  input wire [4*NUM_INST-1:0] mask_retain_o,
  input wire irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire cause0 = hp_reached_i[0] | lp_reached_i[0] | overflow_i[0]
    | underflow_i[0] | handler_done_i[0];
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_ready_bound: assert property ($rose(psel_i && penable_i) |->
    ##[0:2] pready_o) else $error("no pready in time");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access");
  a_slverr_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_start_one_pulse: assert property (handler_start_o[0] |=>
    !handler_start_o[0]) else $error("start pulse too long");
  a_start_has_cause: assert property ($rose(handler_start_o[0]) |->
    $past(cause0, 3)) else $error("start without event or done");
  a_mask_by_program: assert property ($changed(mask_retain_o) |->
    $past(psel_i) || $past(psel_i, 2) || $past(mask_restore_valid_i, 3))
    else $error("mask changed by itself");
  a_id_by_config: assert property ($changed(handler_id_o) |->
    $past(psel_i) || $past(psel_i, 2)) else $error("handler id changed");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |->
    !irq_o && handler_start_o == 0) else $error("output busy in reset");
  c_start: cover property ($rose(handler_start_o[0]));
  c_slverr: cover property (pslverr_o);
  c_irq: cover property ($rose(irq_o));
endmodule // cei_monitor
bind cei_ctrl cei_monitor #(.NUM_INST(NUM_INST)) u_mon (.clock_i,
  .resetn_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o,
  .hp_reached_i, .lp_reached_i, .overflow_i, .underflow_i,
  .mask_restore_valid_i, .handler_done_i, .handler_start_o,
  .handler_id_o, .mask_retain_o, .irq_o);

/* verif/testbench.sv */
// self-checking bench for the counter irq controller
`timescale 1ns/10ps
module testbench;
  reg clock_i = 0, resetn_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  reg [11:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0, rd;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, irq_o;
  reg [3:0] ev = 0;
  wire [5:0] hp_reached_i = {6{ev[0]}}, lp_reached_i = {6{ev[1]}};
  wire [5:0] overflow_i = {6{ev[2]}}, underflow_i = {6{ev[3]}};
  reg [23:0] counter_mode_i = 0, mask_restore_i = 0;
  reg [5:0] autostart_bit_i = 6'h3f;
  reg mask_restore_valid_i = 0, run_mode_i = 0, stall_i = 0, slv;
  wire [5:0] handler_done_i, handler_start_o;
  wire [17:0] handler_id_o;
  wire [23:0] mask_retain_o;
  integer n_errors = 0, compares = 0, nst = 0, cyc = 0, n0, i;
  // nibbles: event, mask, counter mode, expected starts
  reg [15:0] rows [0:9] = '{16'h0101, 16'h0000, 16'h2401, 16'h2b00,
    16'h3821, 16'h3810, 16'h3790, 16'h1291, 16'h1200, 16'h12a0};
  cei_ctrl uut (.clock_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .hp_reached_i,
    .lp_reached_i, .overflow_i, .underflow_i, .counter_mode_i,
    .autostart_bit_i, .mask_restore_i, .mask_restore_valid_i, .run_mode_i,
    .handler_done_i, .handler_start_o, .handler_id_o, .mask_retain_o,
    .irq_o);
  cei_exec_model u_exec (.clock_i, .start_i(handler_start_o), .stall_i,
    .delay_i(8'h02), .done_o(handler_done_i));
  initial forever #10 clock_i = ~clock_i;
  task conclude;
    begin
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ---------------------------------------------
  // cycle count, start count and hang limit
  // ---------------------------------------------
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (handler_start_o[0] === 1'b1)
      nst <= nst + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one setup cycle, then access held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      slv = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task fire(input [3:0] k);
    begin
      @(posedge clock_i);
      ev[k] <= 1'b1;
      repeat (4) @(posedge clock_i);
      ev[k] <= 1'b0;
      repeat (26) @(posedge clock_i);
    end
  endtask
  initial
  begin
    resetn_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rdchk(12'h000, 32'h0);
    rdchk(12'h008, 32'h0);
    rdchk(12'h020, 32'h0);
    chk({31'h0, slv}, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    rdchk(12'h004, 32'h3f);
    apb(1'b1, 12'h01c, 32'h2c688);
    repeat (2) @(posedge clock_i);
    chk({14'h0, handler_id_o}, 32'h2c688);
    mask_restore_i <= 24'ha5a5a5;
    mask_restore_valid_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    mask_restore_valid_i <= 1'b0;
    rdchk(12'h000, 32'ha5a5a5);
    run_mode_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rdchk(12'h008, 32'h3f);
    $display("test reset and config done");
    for (i = 0; i < 10; i = i + 1)
    begin
      apb(1'b1, 12'h000, {28'h0, rows[i][11:8]});
      counter_mode_i <= {6{rows[i][7:4]}};
      n0 = nst;
      fire(rows[i][15:12]);
      chk(nst - n0, {28'h0, rows[i][3:0]});
      chk({28'h0, mask_retain_o[3:0]}, {28'h0, rows[i][11:8]});
      rdchk(12'h008, 32'h3f);
    end
    $display("test event masks done");
    apb(1'b1, 12'h000, 32'h1);
    stall_i <= 1'b1;
    n0 = nst;
    fire(4'h0);
    fire(4'h0);
    fire(4'h0);
    apb(1'b1, 12'h008, 32'h0);
    rdchk(12'h008, 32'h1013f);
    rdchk(12'h00c, 32'h1);
    apb(1'b1, 12'h018, 32'h1);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b1, 12'h018, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b1, 12'h014, 32'h1);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    rdchk(12'h010, 32'h2);
    apb(1'b1, 12'h00c, 32'h1);
    rdchk(12'h00c, 32'h0);
    stall_i <= 1'b0;
    repeat (40) @(posedge clock_i);
    chk(nst - n0, 32'h2);
    rdchk(12'h008, 32'h3f);
    $display("test pending and lost done");
    run_mode_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    rdchk(12'h008, 32'h0);
    $display("test run mode exit done");
    apb(1'b1, 12'h018, 32'h3);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    resetn_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rdchk(12'h010, 32'h0);
    rdchk(12'h000, 32'h0);
    chk({14'h0, handler_id_o}, 32'h0);
    mask_restore_valid_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    mask_restore_valid_i <= 1'b0;
    rdchk(12'h000, 32'ha5a5a5);
    $display("test mid-run reset done");
    conclude;
  end
endmodule // testbench
